//--- logic/dsz_pkg.sv
// package for the decrement-and-skip-if-zero execution block
package dsz_pkg;

  // width of a data byte
  localparam int unsigned DATA_W = 8;
  // width of a data memory address
  localparam int unsigned ADDR_W = 8;

  // operation codes presented to the execution block
  typedef enum logic [1:0]
  {
    DSZ_OP_NONE = 2'b00,
    DSZ_OP_MEM  = 2'b01,  // dec_mem_skip_zero
    DSZ_OP_ACC  = 2'b10   // dec_to_acc_skip_zero
  } dsz_op_t;

  // execution sequencer states
  typedef enum logic [0:0]
  {
    DSZ_ST_RUN   = 1'b0,
    DSZ_ST_DUMMY = 1'b1
  } dsz_state_t;

  // request carried from decode to the execution block
  typedef struct packed
  {
    dsz_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   operand;
  } dsz_req_t;

  // memory write-back carried out of the block
  typedef struct packed
  {
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } dsz_wr_t;

  // accumulator reset value, decrement step and zero byte
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [DATA_W-1:0] DEC_STEP   = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  // cycles taken with and without a skip
  localparam int unsigned CYC_SKIP   = 2;
  localparam int unsigned CYC_NOSKIP = 1;

endpackage

//--- logic/dsz_dec_unit.sv
// combinational 8-bit modulo decrement with zero detect
`timescale 1ns/100ps
module dsz_dec_unit
  import dsz_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
)
(
  input  wire logic [WIDTH-1:0] value_in,    // source byte
  output logic      [WIDTH-1:0] result_out,  // source minus one
  output logic                  zero_out     // result is zero
);

  // modulo subtract, zero wraps to all ones
  always_comb
  begin
    result_out = value_in - WIDTH'(DEC_STEP);
    zero_out   = (result_out == '0);
  end

endmodule

//--- logic/dsz_exec.sv
// execution of the two decrement-and-skip-if-zero operations
`timescale 1ns/100ps
module dsz_exec
  import dsz_pkg::*;
(
  input  wire logic              clk_sys_in,        // instruction cycle clock
  input  wire logic              rst_in,            // synchronous reset, high
  input  wire logic              valid_in,          // request presented this cycle
  input  wire dsz_req_t          req_in,            // op, address and memory byte
  output dsz_wr_t                mem_wr_out,        // data memory write-back
  output logic [DATA_W-1:0]      accumulator_reg_out, // accumulator value
  output logic                   flush_out,         // discard the prefetched instruction
  output logic                   stall_out,         // dummy cycle in progress
  output logic                   done_out           // instruction retired
);

  // ==========================================================
  // decrement datapath
  logic [DATA_W-1:0] dec_result;
  logic              dec_zero;

  // modulo decrement of the operand
  dsz_dec_unit #(
    .WIDTH (DATA_W)
  ) u_dec (
    .value_in   (req_in.operand),
    .result_out (dec_result),
    .zero_out   (dec_zero)
  );

  // ==========================================================
  // sequencer and outputs
  dsz_state_t        state;
  dsz_state_t        next_state;
  dsz_wr_t           mem_wr;
  dsz_wr_t           next_mem_wr;
  logic [DATA_W-1:0] accumulator_reg;
  logic [DATA_W-1:0] next_accumulator_reg;
  logic              flush;
  logic              next_flush;
  logic              stall;
  logic              next_stall;
  logic              done;
  logic              next_done;
  logic              accept;

  // op codes that this block executes, all others are refused
  function automatic logic is_dsz_op(input dsz_op_t op);
    return (op == DSZ_OP_MEM) || (op == DSZ_OP_ACC);
  endfunction

  // requests are ignored during the dummy cycle
  assign accept = valid_in && (state == DSZ_ST_RUN)
                  && is_dsz_op(req_in.op);

  // next values of the sequencer and outputs
  always_comb
  begin
    next_state           = state;
    next_mem_wr          = '0;
    next_accumulator_reg = accumulator_reg;
    next_flush           = 1'b0;
    next_stall           = 1'b0;
    next_done            = 1'b0;
    unique case (state)
      DSZ_ST_RUN:
      begin
        if (accept)
        begin
          if (req_in.op == DSZ_OP_MEM)
          begin
            next_mem_wr.we   = 1'b1;
            next_mem_wr.addr = req_in.addr;
            next_mem_wr.data = dec_result;
          end
          else
          begin
            next_accumulator_reg = dec_result;
          end
          if (dec_zero)
          begin
            next_flush = 1'b1;
            next_stall = 1'b1;
            next_state = DSZ_ST_DUMMY;
          end
          else
          begin
            next_done = 1'b1;
          end
        end
      end
      DSZ_ST_DUMMY:
      begin
        next_done  = 1'b1;
        next_state = DSZ_ST_RUN;
      end
    endcase
  end

  // register the sequencer and outputs
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state           <= DSZ_ST_RUN;
      mem_wr          <= '0;
      accumulator_reg <= ACC_RST;
      flush           <= 1'b0;
      stall           <= 1'b0;
      done            <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      mem_wr          <= next_mem_wr;
      accumulator_reg <= next_accumulator_reg;
      flush           <= next_flush;
      stall           <= next_stall;
      done            <= next_done;
    end
  end

  // outputs come straight from the registers
  assign mem_wr_out          = mem_wr;
  assign accumulator_reg_out = accumulator_reg;
  assign flush_out           = flush;
  assign stall_out           = stall;
  assign done_out            = done;

  // ==========================================================
  // checks
  // memory variant writes the decremented byte back to its own address
  chk_mem_writeback: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && req_in.op == DSZ_OP_MEM) |=>
      (mem_wr_out.we && mem_wr_out.addr == $past(req_in.addr)
       && mem_wr_out.data == $past(req_in.operand) - DEC_STEP))
    else $error("memory write-back wrong");

  // a source of one gives zero, which flushes and stalls
  chk_zero_flush: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && req_in.operand == DEC_STEP) |=> flush_out && stall_out)
    else $error("zero result did not flush");

  // a zero result takes the stall cycle and retires one cycle later
  chk_two_cycles: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && dec_zero) |=> (!done_out && stall_out) ##1 (done_out && !stall_out))
    else $error("skip did not take two cycles");

  // a nonzero result retires at once with no inserted cycle
  chk_one_cycle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && !dec_zero) |=> (done_out && !flush_out && !stall_out))
    else $error("nonzero result inserted a cycle");

  // accumulator variant loads the accumulator and writes nothing back
  chk_acc_variant: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && req_in.op == DSZ_OP_ACC) |=>
      (!mem_wr_out.we && accumulator_reg_out == $past(req_in.operand) - DEC_STEP))
    else $error("accumulator variant wrong");

  // a zero source wraps to all ones and does not skip
  chk_zero_wraps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && req_in.operand == ZERO_BYTE) |=> (!flush_out && done_out))
    else $error("zero source skipped");

  // memory variant leaves the accumulator alone
  chk_acc_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (accept && req_in.op == DSZ_OP_MEM) |=> $stable(accumulator_reg_out))
    else $error("memory variant touched accumulator");

  // the dummy cycle is never repeated
  chk_no_double: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    flush_out |=> !flush_out)
    else $error("dummy cycle repeated");

  // anything offered in the dummy cycle is dropped, so the skipped instruction has no effect
  chk_dummy_drops: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    stall_out |=>
      (!mem_wr_out.we && !flush_out && !stall_out && $stable(accumulator_reg_out)))
    else $error("request taken in the dummy cycle");

  // in the run state, refused or absent requests leave every pulse output quiet
  chk_refused_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == DSZ_ST_RUN && !accept) |=>
      (!mem_wr_out.we && !flush_out && !stall_out && !done_out))
    else $error("refused request produced output");

  // flush and stall always come together, in the dummy cycle
  chk_flush_stall: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    flush_out |->
      (stall_out && !done_out && state == DSZ_ST_DUMMY))
    else $error("flush without stall");

  // the write-back bus reads zero when no write is under way
  chk_idle_bus: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !mem_wr_out.we |->
      (mem_wr_out.addr == '0 && mem_wr_out.data == '0))
    else $error("write-back bus not idle");

  // reset clears the sequencer outputs and the accumulator
  chk_reset_clear: assert property (@(posedge clk_sys_in)
    rst_in |=>
      (mem_wr_out == '0 && !flush_out && !stall_out && !done_out && accumulator_reg_out == ACC_RST))
    else $error("reset did not clear outputs");

  // ==========================================================
  // coverage of the main scenarios
  cov_mem_skip: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    accept && req_in.op == DSZ_OP_MEM && dec_zero);
  cov_acc_skip: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    accept && req_in.op == DSZ_OP_ACC && dec_zero);
  cov_no_skip: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    accept && !dec_zero);
  cov_wrap: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    accept && req_in.operand == ZERO_BYTE);
  cov_dummy_request: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    stall_out && valid_in);

endmodule

//--- testbench/dsz_exec_test.sv
// self-checking bench for the decrement-and-skip-if-zero execution block
`timescale 1ns/100ps
module dsz_exec_test;
  import dsz_pkg::*;
  // ==========================================
  // signals and model state
  logic              clk_sys_in = 1'b0;  // bench clock
  logic              rst_in     = 1'b1;  // bench reset
  logic              valid_in   = 1'b0;  // request valid
  dsz_req_t          req_in     = '0;    // request
  dsz_wr_t           mem_wr_out;
  logic [DATA_W-1:0] accumulator_reg_out;
  logic              flush_out;
  logic              stall_out;
  logic              done_out;
  int                n_errors = 0;
  int                compares = 0;
  logic [31:0]       seed     = 32'hfb45_2a09;
  int                m_acc, m_busy, m_pend, e_we, e_addr, e_data, e_fl, e_st, e_dn, r;

  // clock, 20 ns period
  always #10 clk_sys_in = ~clk_sys_in;

  dsz_exec dut_u
  (
    .clk_sys_in          (clk_sys_in),
    .rst_in              (rst_in),
    .valid_in            (valid_in),
    .req_in              (req_in),
    .mem_wr_out          (mem_wr_out),
    .accumulator_reg_out (accumulator_reg_out),
    .flush_out           (flush_out),
    .stall_out           (stall_out),
    .done_out            (done_out)
  );

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // model the edge that samples current inputs, drive the next ones, compare at the falling edge
  task automatic step(input logic rs, input logic v, input logic [1:0] o, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk_sys_in);
    e_we = 0; e_fl = 0; e_st = 0; e_dn = m_pend; m_pend = 0;
    if (rst_in)
    begin
      m_acc = 0; m_busy = 0; e_dn = 0;
    end
    else if (m_busy != 0)
      m_busy = 0;  // request in the dummy cycle is dropped
    else if (valid_in && (req_in.op == DSZ_OP_MEM || req_in.op == DSZ_OP_ACC))
    begin
      r = (int'(req_in.operand) + 255) % 256;
      if (req_in.op == DSZ_OP_MEM)
      begin
        e_we = 1; e_addr = req_in.addr; e_data = r;
      end
      else
        m_acc = r;
      if (r == 0)
      begin
        e_fl = 1; e_st = 1; m_busy = 1; m_pend = 1;
      end
      else
        e_dn = 1;
    end
    rst_in <= rs;
    valid_in <= v;
    req_in <= {o, a, d};
    @(negedge clk_sys_in);
    check("write_enable", mem_wr_out.we, e_we);
    if (e_we != 0)
      check("write_addr_data", {mem_wr_out.addr, mem_wr_out.data}, {e_addr[7:0], e_data[7:0]});
    else
      check("write_idle", {mem_wr_out.addr, mem_wr_out.data}, 32'h0000_0000);
    check("accumulator", accumulator_reg_out, m_acc);
    check("flush", flush_out, e_fl);
    check("stall", stall_out, e_st);
    check("done", done_out, e_dn);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    m_acc = 0; m_busy = 0; m_pend = 0;
    repeat (4) step(1, 0, 2'b00, 8'h00, 8'h00);
    // zero skip, request in stall, wrap, ignored op, accumulator skip, back to back
    step(0, 1, 2'b01, 8'h20, 8'h01);
    step(0, 1, 2'b10, 8'h21, 8'h05);
    step(0, 1, 2'b10, 8'h22, 8'h05);
    step(0, 1, 2'b01, 8'h23, 8'h00);
    step(0, 1, 2'b11, 8'h24, 8'h01);
    step(0, 1, 2'b10, 8'h25, 8'h01);
    step(0, 1, 2'b01, 8'h26, 8'h01);
    step(0, 1, 2'b01, 8'h27, 8'h09);
    step(1, 0, 2'b00, 8'h00, 8'h00);
    repeat (3) step(0, 0, 2'b00, 8'h00, 8'h00);
    $display("test directed finished");
    // random mix with occasional resets
    repeat (800)
    begin
      seed = xs(seed);
      step(seed[31:25] == 0, seed[12:10] != 0, seed[14:13], seed[23:16],
           seed[9:8] == 0 ? 8'h00 : seed[9:8] == 1 ? 8'h01 : seed[7:0]);
    end
    repeat (2) step(0, 0, 2'b00, 8'h00, 8'h00);
    $display("test random finished");
    tally_and_finish();
  end
endmodule
